// >>> rtl/usb_config_endpoint_regs.sv
// Module: AHB-Lite register block for USB descriptor table base, configuration and endpoint control
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps

// Notes on behaviour
// - Table base bits 23:16 come from the eight bits of the middle page register.
// - Table base bits 31:24 come from the eight bits of the top page register.
// - Table base bits 15:9 come from low register bits 7:1; bit 0 absent.
// - Table base is 32 bits, 512-byte aligned; bits 8:0 always zero.
// - Bits 31:8 read as zero, except on the 16-bit interrupt status and mask registers, which read zero in bits 31:16.
// - All implemented control bits reset to zero.
// - Configuration bit 7 enables the transceiver eye-pattern test.
// - Configuration bit 6 lets the drive monitor follow the D+/D- drive enable.
// - Configuration bit 4 stops the module while the system is idle.
// - Configuration bit 0 suspends the module automatically on sleep entry.
// - Host mode, endpoint 0 bit 7 selects direct low-speed, else PRE through hub.
// - Host mode, endpoint 0 bit 6 clear lets hardware retry NAKed transactions.
// - With both directions on, bit 4 blocks SETUP transfers; otherwise it is ignored.
// - Endpoint bit 3 enables reception on that endpoint.
// - Endpoint bit 2 enables transmission on that endpoint.
// - Endpoint bit 1 reads one once the endpoint has been stalled.
// - Endpoint bit 0 enables handshakes; clear suppresses them, as for isochronous use.
module usb_config_endpoint_regs
    import usb_cfg_ep_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // System power state and USB engine status
    input  wire logic        sys_idle_i,
    input  wire logic        sys_sleep_i,
    input  wire logic        manual_suspend_i,
    input  wire logic        line_drive_i,
    input  wire logic [15:0] ep_stall_event_i,
    // Controls towards the USB engine
    output logic      [31:0] table_base_o,
    output logic             eye_test_enable_o,
    output logic             drive_monitor_o,
    output logic             module_run_o,
    output logic             module_suspend_o,
    output logic             low_speed_direct_o,
    output logic             nak_retry_on_o,
    output logic      [15:0] ep_receive_on_o,
    output logic      [15:0] ep_transmit_on_o,
    output logic      [15:0] ep_setup_allowed_o,
    output logic      [15:0] ep_handshake_on_o,
    // Interrupt
    output logic             irq_o
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0]  table_base_low_bits;
    logic [7:0]  table_base_mid_bits;
    logic [7:0]  table_base_top_bits;
    logic [7:0]  usb_config_one;
    logic [7:0]  endpoint_control [NUM_ENDPOINTS];
    logic [15:0] irq_status;
    logic [15:0] irq_mask;

    // ************************************************************
    // AHB-Lite address phase capture
    // ************************************************************
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rd_word;

    wire         addr_phase = hsel_i && hready_i && htrans_i[1];
    wire         rd_take    = addr_phase && !hwrite_i;
    wire         wr_take    = addr_phase && hwrite_i;
    wire [7:0]   a_off      = haddr_i[7:0];
    wire         a_is_ep    = (a_off >= OFF_ENDPOINT_BASE) && (a_off <= OFF_ENDPOINT_LAST)
                              && (haddr_i[31:8] == 24'h000000);
    wire [3:0]   a_ep_idx   = a_off[5:2];
    wire         w_is_ep    = (wr_addr >= OFF_ENDPOINT_BASE) && (wr_addr <= OFF_ENDPOINT_LAST);
    wire [3:0]   w_ep_idx   = wr_addr[5:2];
    wire [7:0]   wbyte      = hwdata_i[7:0];

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= wr_take;
            wr_addr <= (wr_take && haddr_i[31:8] == 24'h000000) ? a_off : 8'hff;
        end
    end

    // Unmapped reads return zero; upper 24 bits are zero, upper 16 bits for interrupt status and mask
    always_comb begin
        rd_word = 32'h0000_0000;
        if (a_is_ep) begin
            rd_word[7:0] = endpoint_control[a_ep_idx];
        end else if (haddr_i[31:8] == 24'h000000) begin
            unique case (a_off)
                OFF_TABLE_BASE_LOW: rd_word[7:0] = table_base_low_bits;
                OFF_TABLE_BASE_MID: rd_word[7:0] = table_base_mid_bits;
                OFF_TABLE_BASE_TOP: rd_word[7:0] = table_base_top_bits;
                OFF_USB_CONFIG_ONE: rd_word[7:0] = usb_config_one;
                OFF_IRQ_STATUS:     rd_word[15:0] = irq_status;
                OFF_IRQ_MASK:       rd_word[15:0] = irq_mask;
                default:            rd_word = 32'h0000_0000;
            endcase
        end
    end

    // Zero wait states: answer stands in the cycle after the address phase
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hrdata_o    <= rd_take ? rd_word : 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    wire wr_low  = wr_pend && (wr_addr == OFF_TABLE_BASE_LOW);
    wire wr_mid  = wr_pend && (wr_addr == OFF_TABLE_BASE_MID);
    wire wr_top  = wr_pend && (wr_addr == OFF_TABLE_BASE_TOP);
    wire wr_cfg  = wr_pend && (wr_addr == OFF_USB_CONFIG_ONE);
    wire wr_stat = wr_pend && (wr_addr == OFF_IRQ_STATUS);
    wire wr_mask = wr_pend && (wr_addr == OFF_IRQ_MASK);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            table_base_low_bits <= REG_RESET;
            table_base_mid_bits <= REG_RESET;
            table_base_top_bits <= REG_RESET;
            usb_config_one      <= REG_RESET;
            irq_mask            <= 16'h0000;
        end else begin
            if (wr_low) table_base_low_bits <= wbyte & LOW_WRITE_MASK;
            if (wr_mid) table_base_mid_bits <= wbyte;
            if (wr_top) table_base_top_bits <= wbyte;
            if (wr_cfg) usb_config_one <= wbyte & CFG_WRITE_MASK;
            if (wr_mask) irq_mask <= hwdata_i[15:0];
        end
    end

    // ************************************************************
    // Endpoint registers, one per endpoint
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_ENDPOINTS; g++) begin : g_ep
            wire ep_wr = wr_pend && w_is_ep && (w_ep_idx == 4'(g));
            wire [7:0] ep_wmask = (g == 0) ? EP_WRITE_MASK : (EP_WRITE_MASK & 8'h3f);
            // Stall flag is hardware set; software may clear it by writing zero.
            // A stall in the same cycle as the write wins.
            wire next_stall = ep_stall_event_i[g] ||
                              (ep_wr ? wbyte[EP_STALLED_BIT] & endpoint_control[g][EP_STALLED_BIT]
                                     : endpoint_control[g][EP_STALLED_BIT]);
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    endpoint_control[g] <= REG_RESET;
                end else begin
                    if (ep_wr) begin
                        endpoint_control[g] <= wbyte & ep_wmask;
                    end
                    endpoint_control[g][EP_STALLED_BIT] <= next_stall;
                end
            end

            wire rx_on = endpoint_control[g][EP_RECEIVE_BIT];
            wire tx_on = endpoint_control[g][EP_TRANSMIT_BIT];
            wire blk   = rx_on && tx_on && endpoint_control[g][EP_CTRL_BLOCK_BIT];
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    ep_receive_on_o[g]    <= 1'b0;
                    ep_transmit_on_o[g]   <= 1'b0;
                    ep_setup_allowed_o[g] <= 1'b0;
                    ep_handshake_on_o[g]  <= 1'b0;
                end else begin
                    ep_receive_on_o[g]    <= rx_on;
                    ep_transmit_on_o[g]   <= tx_on;
                    ep_setup_allowed_o[g] <= (rx_on || tx_on) && !blk;
                    ep_handshake_on_o[g]  <= endpoint_control[g][EP_HANDSHAKE_BIT];
                end
            end
        end
    endgenerate

    // ************************************************************
    // Interrupt: one sticky bit per endpoint stall, write one to clear
    // ************************************************************
    wire [15:0] stat_clear  = wr_stat ? hwdata_i[15:0] : 16'h0000;
    wire [15:0] next_status = ep_stall_event_i | (irq_status & ~stat_clear);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_status <= 16'h0000;
            irq_o      <= 1'b0;
        end else begin
            irq_status <= next_status;
            irq_o      <= |(next_status & irq_mask);
        end
    end

    // ************************************************************
    // Control outputs
    // ************************************************************
    wire [31:0] next_base = {table_base_top_bits, table_base_mid_bits,
                             table_base_low_bits[7:1], {BASE_ALIGN_BITS{1'b0}}};
    wire idle_halt  = usb_config_one[CFG_IDLE_STOP_BIT] && sys_idle_i;
    wire auto_susp  = usb_config_one[CFG_AUTO_SUSPEND_BIT] && sys_sleep_i;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            table_base_o       <= 32'h0000_0000;
            eye_test_enable_o  <= 1'b0;
            drive_monitor_o    <= 1'b0;
            module_run_o       <= 1'b0;
            module_suspend_o   <= 1'b0;
            low_speed_direct_o <= 1'b0;
            nak_retry_on_o     <= 1'b0;
        end else begin
            table_base_o       <= next_base;
            eye_test_enable_o  <= usb_config_one[CFG_EYE_TEST_BIT];
            drive_monitor_o    <= usb_config_one[CFG_DRIVE_MON_BIT] && line_drive_i;
            module_run_o       <= !idle_halt && !auto_susp && !manual_suspend_i;
            module_suspend_o   <= auto_susp || manual_suspend_i;
            low_speed_direct_o <= endpoint_control[0][EP_LOW_SPEED_BIT];
            nak_retry_on_o     <= !endpoint_control[0][EP_NAK_RETRY_BIT];
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_mid_write;
        wr_mid;
    endsequence

    a_base_align_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        table_base_o[8:0] == 9'h000) else $error("table base not aligned");

    a_base_mid_load: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        s_mid_write |=> ##1 (table_base_o[23:16] == $past(wbyte, 2))) else $error("mid byte not in base");

    a_base_top_load: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_top |=> ##1 (table_base_o[31:24] == $past(wbyte, 2))) else $error("top byte not in base");

    a_read_upper_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rd_take |=> (hrdata_o[31:16] == 16'h0000)) else $error("upper read bits not zero");

    a_eye_test_follow: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_cfg |=> ##1 (eye_test_enable_o == $past(wbyte[CFG_EYE_TEST_BIT], 2))) else $error("eye test wrong");

    a_monitor_gated: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !usb_config_one[CFG_DRIVE_MON_BIT] ##1 !usb_config_one[CFG_DRIVE_MON_BIT] |-> !drive_monitor_o)
        else $error("drive monitor active while disabled");

    a_idle_stop_halt: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        idle_halt |=> !module_run_o) else $error("module runs in idle stop");

    a_sleep_suspend: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        auto_susp |=> module_suspend_o) else $error("no auto suspend on sleep");

    a_stall_sticky: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        ep_stall_event_i[0] |=> endpoint_control[0][EP_STALLED_BIT]) else $error("stall flag not set");

    a_setup_blocked: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (endpoint_control[0][4:2] == 3'b111) |=> !ep_setup_allowed_o[0]) else $error("setup not blocked");

    a_nak_retry_ep0: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        endpoint_control[0][EP_NAK_RETRY_BIT] |=> !nak_retry_on_o) else $error("retry on while disabled");

    // ************************************************************
    // Register contents and output follow-through
    // ************************************************************
    // Both directions of the config, NAK retry and setup controls are covered, so a stuck output there trips one of them
    sequence s_low_write;
        wr_low;
    endsequence

    sequence s_stat_clear;
        wr_stat && hwdata_i[0] && !ep_stall_event_i[0];
    endsequence

    a_base_low_load: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        s_low_write |=> ##1 (table_base_o[15:9] == $past(wbyte[7:1], 2))) else $error("low bits not in base");

    a_low_bit_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        table_base_low_bits[0] == 1'b0) else $error("unimplemented low bit set");

    a_mid_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !wr_mid |=> (table_base_mid_bits == $past(table_base_mid_bits))) else $error("mid byte changed");

    a_top_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !wr_top |=> (table_base_top_bits == $past(table_base_top_bits))) else $error("top byte changed");

    a_cfg_unused_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (usb_config_one & ~CFG_WRITE_MASK) == 8'h00) else $error("unused config bit set");

    a_ep_unused_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        endpoint_control[0][5] == 1'b0) else $error("unused endpoint bit set");

    a_cfg_read_low: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rd_take && (a_off == OFF_USB_CONFIG_ONE) |=> (hrdata_o[31:8] == 24'h000000))
        else $error("config read upper bits set");

    a_eye_test_off: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !usb_config_one[CFG_EYE_TEST_BIT] |=> !eye_test_enable_o) else $error("eye test on while clear");

    a_monitor_follow: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        usb_config_one[CFG_DRIVE_MON_BIT] && line_drive_i |=> drive_monitor_o) else $error("monitor missed drive");

    a_run_in_idle: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !usb_config_one[CFG_IDLE_STOP_BIT] && !sys_sleep_i && !manual_suspend_i |=> module_run_o)
        else $error("module stopped without cause");

    a_no_auto_susp: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !usb_config_one[CFG_AUTO_SUSPEND_BIT] && !manual_suspend_i |=> !module_suspend_o)
        else $error("suspend without cause");

    a_manual_susp: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        manual_suspend_i |=> module_suspend_o && !module_run_o) else $error("manual suspend ignored");

    a_low_speed_ep0: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        endpoint_control[0][EP_LOW_SPEED_BIT] |=> low_speed_direct_o) else $error("low speed not driven");

    a_retry_on_ep0: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !endpoint_control[0][EP_NAK_RETRY_BIT] |=> nak_retry_on_o) else $error("retry off while enabled");

    a_setup_open: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !endpoint_control[0][EP_CTRL_BLOCK_BIT] && endpoint_control[0][EP_RECEIVE_BIT] |=> ep_setup_allowed_o[0])
        else $error("setup blocked while allowed");

    a_receive_follow: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        endpoint_control[0][EP_RECEIVE_BIT] |=> ep_receive_on_o[0]) else $error("receive not enabled");

    a_transmit_follow: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        endpoint_control[0][EP_TRANSMIT_BIT] |=> ep_transmit_on_o[0]) else $error("transmit not enabled");

    a_stall_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        endpoint_control[0][EP_STALLED_BIT] && !g_ep[0].ep_wr |=> endpoint_control[0][EP_STALLED_BIT])
        else $error("stall flag lost");

    a_status_clear: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        s_stat_clear |=> !irq_status[0]) else $error("status not cleared");

    a_irq_masked: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (irq_mask == 16'h0000) |=> !irq_o) else $error("interrupt while masked");

    a_handshake_off: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !endpoint_control[0][EP_HANDSHAKE_BIT] |=> !ep_handshake_on_o[0]) else $error("handshake on while off");

    a_ep15_layout: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        endpoint_control[15][7:6] == 2'b00) else $error("host bits set on endpoint 15");

endmodule

// >>> common/usb_cfg_ep_pkg.sv
// Package: register map, field positions and reset values of the USB configuration and endpoint registers
package usb_cfg_ep_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFF_TABLE_BASE_LOW  = 8'h00;
    localparam logic [7:0] OFF_TABLE_BASE_MID  = 8'h04;
    localparam logic [7:0] OFF_TABLE_BASE_TOP  = 8'h08;
    localparam logic [7:0] OFF_USB_CONFIG_ONE  = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STATUS      = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK        = 8'h14;
    localparam logic [7:0] OFF_ENDPOINT_BASE   = 8'h40;
    localparam logic [7:0] OFF_ENDPOINT_LAST   = 8'h7c;

    localparam int         NUM_ENDPOINTS       = 16;

    // ************************************************************
    // Configuration register fields
    // ************************************************************
    localparam int CFG_EYE_TEST_BIT     = 7;
    localparam int CFG_DRIVE_MON_BIT    = 6;
    localparam int CFG_IDLE_STOP_BIT    = 4;
    localparam int CFG_AUTO_SUSPEND_BIT = 0;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hd1;

    // ************************************************************
    // Endpoint register fields
    // ************************************************************
    localparam int EP_LOW_SPEED_BIT   = 7;
    localparam int EP_NAK_RETRY_BIT   = 6;
    localparam int EP_CTRL_BLOCK_BIT  = 4;
    localparam int EP_RECEIVE_BIT     = 3;
    localparam int EP_TRANSMIT_BIT    = 2;
    localparam int EP_STALLED_BIT     = 1;
    localparam int EP_HANDSHAKE_BIT   = 0;
    localparam logic [7:0] EP_WRITE_MASK = 8'hdd;

    // Table base: low register holds bits 15:9, bit 0 unimplemented
    localparam logic [7:0] LOW_WRITE_MASK = 8'hfe;
    localparam int         BASE_ALIGN_BITS = 9;

    localparam logic [7:0] REG_RESET = 8'h00;

    // ************************************************************
    // AHB-Lite encodings
    // ************************************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ    = 2'b11;

endpackage

// >>> verification/usb_engine_model.sv
// Far-side model: system power state and USB engine line and stall activity
`timescale 1ns/100ps
module usb_engine_model (
    // Clock
    input  wire logic        sys_clk_i,
    // Towards the register block
    output logic             sys_idle_o,
    output logic             sys_sleep_o,
    output logic             manual_suspend_o,
    output logic             line_drive_o,
    output logic      [15:0] ep_stall_event_o
);
    initial begin
        sys_idle_o       = 1'b0;
        sys_sleep_o      = 1'b0;
        manual_suspend_o = 1'b0;
        line_drive_o     = 1'b0;
        ep_stall_event_o = 16'h0000;
    end

    // Software suspends by hand when auto suspend is off
    task automatic set_power(input logic idle, input logic sleep, input logic susp);
        @(posedge sys_clk_i);
        sys_idle_o       <= idle;
        sys_sleep_o      <= sleep;
        manual_suspend_o <= susp;
    endtask

    task automatic drive_line(input logic on);
        @(posedge sys_clk_i);
        line_drive_o <= on;
    endtask

    // One-cycle stall pulse on a single endpoint
    task automatic stall(input int n);
        @(posedge sys_clk_i);
        ep_stall_event_o <= 16'h0001 << n;
        @(posedge sys_clk_i);
        ep_stall_event_o <= 16'h0000;
    endtask
endmodule

// >>> verification/usb_config_endpoint_regs_tb_top.sv
// Testbench: register access, table base, power gating, endpoint controls and stall interrupt
`timescale 1ns/100ps
module usb_config_endpoint_regs_tb_top;
    import usb_cfg_ep_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic        sys_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic [1:0]  htrans  = 2'b00;
    logic [31:0] haddr   = 32'h0;
    logic [31:0] hwdata  = 32'h0;
    logic [31:0] hrdata, table_base;
    logic        hready, hresp, eye, mon, run, susp, lsd, nak, irq, idle, sleep, msusp, line;
    logic [15:0] stall, rx, tx, setup, hs;
    int          err_count    = 0;
    int          total_checks = 0;

    always #50 sys_clk = ~sys_clk;

    usb_config_endpoint_regs u_dut (
        .sys_clk_i(sys_clk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .sys_idle_i(idle), .sys_sleep_i(sleep),
        .manual_suspend_i(msusp), .line_drive_i(line), .ep_stall_event_i(stall), .table_base_o(table_base),
        .eye_test_enable_o(eye), .drive_monitor_o(mon), .module_run_o(run), .module_suspend_o(susp),
        .low_speed_direct_o(lsd), .nak_retry_on_o(nak), .ep_receive_on_o(rx), .ep_transmit_on_o(tx),
        .ep_setup_allowed_o(setup), .ep_handshake_on_o(hs), .irq_o(irq));

    usb_engine_model u_far (
        .sys_clk_i(sys_clk), .sys_idle_o(idle), .sys_sleep_o(sleep), .manual_suspend_o(msusp),
        .line_drive_o(line), .ep_stall_event_o(stall));

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait so a stuck slave cannot hang one transfer forever
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        chk({31'h0, hready}, 32'h1);
    endtask

    task automatic bus_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                            output logic [31:0] rd);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr  <= {24'h0, addr};
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr_reg(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        bus_xfer(1'b1, addr, wd, rd);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        bus_xfer(1'b0, addr, 32'h0, rd);
        chk(rd, exp);
    endtask

    // Outputs are registered behind the register, so let them land first
    task automatic settle;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic ep_chk(input logic [15:0] erx, etx, esetup, ehs);
        settle();
        chk({rx, tx}, {erx, etx});
        chk({setup, hs}, {esetup, ehs});
    endtask

    task automatic complete_run;
        $display("Checks: %0d, errors: %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) rd_chk(8'(4 * i), 32'h0);
        for (int i = 0; i < 16; i++) rd_chk(OFF_ENDPOINT_BASE + 8'(4 * i), 32'h0);
        settle();
        chk(table_base, 32'h0);
        chk({25'h0, eye, mon, run, susp, lsd, nak, irq}, 32'h12);
        ep_chk(16'h0, 16'h0, 16'h0, 16'h0);
        wr_reg(OFF_TABLE_BASE_LOW, 32'hffff_ffff);
        rd_chk(OFF_TABLE_BASE_LOW, 32'h0000_00fe);
        wr_reg(OFF_TABLE_BASE_MID, 32'h1234_56a5);
        rd_chk(OFF_TABLE_BASE_MID, 32'h0000_00a5);
        wr_reg(OFF_TABLE_BASE_TOP, 32'hffff_ff3c);
        rd_chk(OFF_TABLE_BASE_TOP, 32'h0000_003c);
        settle();
        chk(table_base, 32'h3ca5_fe00);
        wr_reg(OFF_TABLE_BASE_LOW, 32'h0000_0003);
        settle();
        chk(table_base, 32'h3ca5_0200);
        wr_reg(OFF_USB_CONFIG_ONE, 32'hffff_ffff);
        rd_chk(OFF_USB_CONFIG_ONE, 32'h0000_00d1);
        settle();
        chk({eye, mon}, 2'b10);
        u_far.drive_line(1'b1);
        settle();
        chk({31'h0, mon}, 32'h1);
        u_far.set_power(1'b1, 1'b0, 1'b0);
        settle();
        chk({run, susp}, 2'b00);
        u_far.set_power(1'b0, 1'b1, 1'b0);
        settle();
        chk({run, susp}, 2'b01);
        wr_reg(OFF_USB_CONFIG_ONE, 32'h0);
        u_far.set_power(1'b1, 1'b1, 1'b0);
        settle();
        chk({eye, mon, run, susp}, 4'b0010);
        u_far.set_power(1'b0, 1'b0, 1'b1);
        settle();
        chk({run, susp}, 2'b01);
        u_far.set_power(1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 16; i++) wr_reg(OFF_ENDPOINT_BASE + 8'(4 * i), 32'hffff_ffff);
        rd_chk(OFF_ENDPOINT_BASE, 32'h0000_00dd);
        for (int i = 1; i < 16; i++) rd_chk(OFF_ENDPOINT_BASE + 8'(4 * i), 32'h1d);
        ep_chk(16'hffff, 16'hffff, 16'h0000, 16'hffff);
        chk({lsd, nak}, 2'b10);
        for (int i = 0; i < 16; i++) wr_reg(OFF_ENDPOINT_BASE + 8'(4 * i), i[0] ? 32'h14 : 32'h18);
        ep_chk(16'h5555, 16'haaaa, 16'hffff, 16'h0000);
        chk({lsd, nak}, 2'b01);
        wr_reg(OFF_ENDPOINT_BASE + 8'h0c, 32'h0d);
        ep_chk(16'h555d, 16'haaaa, 16'hffff, 16'h0008);
        wr_reg(OFF_ENDPOINT_BASE + 8'h0c, 32'h1d);
        ep_chk(16'h555d, 16'haaaa, 16'hfff7, 16'h0008);
        u_far.stall(5);
        settle();
        rd_chk(OFF_ENDPOINT_BASE + 8'h14, 32'h16);
        rd_chk(OFF_IRQ_STATUS, 32'h20);
        chk({31'h0, irq}, 32'h0);
        wr_reg(OFF_IRQ_MASK, 32'h20);
        settle();
        chk({31'h0, irq}, 32'h1);
        wr_reg(OFF_IRQ_STATUS, 32'h20);
        settle();
        chk({31'h0, irq}, 32'h0);
        wr_reg(OFF_ENDPOINT_BASE + 8'h14, 32'h14);
        rd_chk(OFF_ENDPOINT_BASE + 8'h14, 32'h14);
        wr_reg(8'h20, 32'hffff_ffff);
        rd_chk(8'h20, 32'h0);
        complete_run();
    end

    // Watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        complete_run();
    end
endmodule
